// ---- include/radio_regs_pkg.sv ----
// shared constants and types for the radio retry, rf and status register bank
package radio_regs_pkg;

    // register addresses
    localparam logic [4:0] ADDR_RETRANSMIT_DELAY_COUNT = 5'h04;
    localparam logic [4:0] ADDR_RF_CHANNEL_SELECT = 5'h05;
    localparam logic [4:0] ADDR_RF_RATE_POWER_SETUP = 5'h06;
    localparam logic [4:0] ADDR_EVENT_AND_PIPE_FLAGS = 5'h07;

    // command byte: top three bits pick the operation, low five the address
    localparam logic [2:0] CMD_OP_READ = 3'h0;
    localparam logic [2:0] CMD_OP_WRITE = 3'h1;
    localparam int CMD_OP_MSB = 7;
    localparam int CMD_OP_LSB = 5;
    localparam int CMD_ADDR_MSB = 4;

    // retransmit_delay_count fields
    localparam int RETRY_DELAY_CODE_MSB = 7;
    localparam int RETRY_DELAY_CODE_LSB = 4;
    localparam int RETRY_LIMIT_MSB = 3;
    localparam int RETRY_LIMIT_LSB = 0;
    localparam logic [7:0] RETRANSMIT_DELAY_COUNT_RESET = 8'h03;

    // rf_channel_select fields
    localparam int RF_CHANNEL_MSB = 6;
    localparam logic [6:0] RF_CHANNEL_RESET = 7'h02;

    // rf_rate_power_setup fields, bits 7:5 reserved
    localparam int PLL_LOCK_FORCE_BIT = 4;
    localparam int AIR_RATE_SELECT_BIT = 3;
    localparam int TX_POWER_LEVEL_MSB = 2;
    localparam int TX_POWER_LEVEL_LSB = 1;
    localparam int RX_AMP_GAIN_BIT = 0;
    localparam int RF_RATE_POWER_SETUP_MSB = 4;
    localparam logic [4:0] RF_RATE_POWER_SETUP_RESET = 5'h0F;

    // event_and_pipe_flags fields, bit 7 reserved
    localparam int RX_READY_FLAG_BIT = 6;
    localparam int TX_SENT_FLAG_BIT = 5;
    localparam int RETRY_EXHAUSTED_FLAG_BIT = 4;
    localparam int EVENT_FLAGS_LSB = 4;
    localparam int RX_PIPE_MSB = 3;
    localparam int RX_PIPE_LSB = 1;
    localparam int TX_FULL_BIT = 0;
    localparam logic [2:0] EVENT_FLAGS_RESET = 3'h0;
    localparam logic [2:0] RX_PIPE_EMPTY = 3'h7;

    // retransmit delay timing
    localparam int RETRY_STEP_US = 250;
    localparam int CORE_CLK_MHZ = 40;
    localparam int RETRY_STEP_CYCLES = RETRY_STEP_US * CORE_CLK_MHZ;
    localparam int STEP_CNT_W = 14;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_CMD = 2'b01,
        SPI_DATA = 2'b10
    } spi_phase_t;

    typedef enum logic [1:0] {
        RETRY_IDLE = 2'b00,
        RETRY_SEND = 2'b01,
        RETRY_LISTEN = 2'b10
    } retry_state_t;

    typedef struct packed {
        spi_phase_t phase;
        logic [2:0] bit_cnt;
        logic [7:0] shift_in;
        logic [7:0] shift_out;
        logic load_pending;
        logic [7:0] cmd;
        logic wrote;
        logic sck_prev;
        logic [7:0] retr;
        logic [6:0] chan;
        logic [4:0] setup;
        logic [2:0] flags;
        logic [2:0] pipe;
        logic tx_full;
        logic irq_n;
        logic miso_oe_n;
    } bank_state_t;

    typedef struct packed {
        retry_state_t state;
        logic [3:0] retries;
        logic [3:0] step;
        logic [STEP_CNT_W-1:0] cyc;
        logic sent;
        logic exhausted;
        logic retransmit;
        logic listening;
    } retry_engine_state_t;

endpackage

// ---- include/retry_if.sv ----
// link between the register bank and the retransmit engine
`timescale 1ns/1ps
interface retry_if;
    logic [3:0] delay_code;
    logic [3:0] retry_limit;
    logic auto_ack;
    logic blocked;
    logic tx_begin;
    logic tx_end;
    logic ack_seen;
    logic tx_sent_evt;
    logic exhausted_evt;
    logic listening;
    logic retransmit;

    modport bank (
        output delay_code,
        output retry_limit,
        output auto_ack,
        output blocked,
        output tx_begin,
        output tx_end,
        output ack_seen,
        input tx_sent_evt,
        input exhausted_evt,
        input listening,
        input retransmit
    );

    modport engine (
        input delay_code,
        input retry_limit,
        input auto_ack,
        input blocked,
        input tx_begin,
        input tx_end,
        input ack_seen,
        output tx_sent_evt,
        output exhausted_evt,
        output listening,
        output retransmit
    );
endinterface

// ---- hw/retry_engine.sv ----
// retransmit sequencer: delay timing, acknowledge listening and retry counting
`timescale 1ns/1ps
module retry_engine #(
    parameter int unsigned STEP_CYCLES = radio_regs_pkg::RETRY_STEP_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    retry_if.engine link
);
    localparam logic [radio_regs_pkg::STEP_CNT_W-1:0] STEP_LAST =
        radio_regs_pkg::STEP_CNT_W'(STEP_CYCLES - 1);

    radio_regs_pkg::retry_engine_state_t st_reg;
    radio_regs_pkg::retry_engine_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.sent = 1'b0;
        st_next.exhausted = 1'b0;
        st_next.retransmit = 1'b0;
        case (st_reg.state)
            radio_regs_pkg::RETRY_IDLE: begin
                // a pending exhausted flag holds off every new packet
                if (link.tx_begin && !link.blocked) begin
                    st_next.state = radio_regs_pkg::RETRY_SEND;
                    st_next.retries = 4'h0;
                end
            end
            radio_regs_pkg::RETRY_SEND: begin
                if (link.tx_end) begin
                    if (link.auto_ack) begin
                        st_next.state = radio_regs_pkg::RETRY_LISTEN;
                        st_next.step = 4'h0;
                        st_next.cyc = '0;
                    end else begin
                        st_next.sent = 1'b1;
                        st_next.state = radio_regs_pkg::RETRY_IDLE;
                    end
                end
            end
            radio_regs_pkg::RETRY_LISTEN: begin
                if (link.ack_seen) begin
                    st_next.sent = 1'b1;
                    st_next.state = radio_regs_pkg::RETRY_IDLE;
                end else if (st_reg.cyc == STEP_LAST) begin
                    st_next.cyc = '0;
                    // code n waits n+1 steps of 250 us
                    if (st_reg.step == link.delay_code) begin
                        if (st_reg.retries < link.retry_limit) begin
                            st_next.retries = st_reg.retries + 4'h1;
                            st_next.retransmit = 1'b1;
                            st_next.state = radio_regs_pkg::RETRY_SEND;
                        end else begin
                            st_next.exhausted = 1'b1;
                            st_next.state = radio_regs_pkg::RETRY_IDLE;
                        end
                    end else begin
                        st_next.step = st_reg.step + 4'h1;
                    end
                end else begin
                    st_next.cyc = st_reg.cyc + 1'b1;
                end
            end
            default: begin
                st_next.state = radio_regs_pkg::RETRY_IDLE;
            end
        endcase
        // receiver stays on for the whole delay window
        st_next.listening = (st_next.state == radio_regs_pkg::RETRY_LISTEN);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '{state: radio_regs_pkg::RETRY_IDLE, retries: 4'h0, step: 4'h0,
                        cyc: '0, sent: 1'b0, exhausted: 1'b0, retransmit: 1'b0,
                        listening: 1'b0};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign link.tx_sent_evt = st_reg.sent;
    assign link.exhausted_evt = st_reg.exhausted;
    assign link.retransmit = st_reg.retransmit;
    assign link.listening = st_reg.listening;
endmodule

// ---- hw/radio_retry_rf_status_regs.sv ----
// spi-reached register bank for retry setup, rf channel, rf_rate_power_setup and status
//
// Overview of operation
// - The retransmit delay code n waits (n+1) times 250 us from the end of one send to the next.
// - During that delay the primary transmitter keeps its receiver on, listening for an acknowledge.
// - The retry limit field in bits 3:0 caps retransmissions, 0 disabling them, and resets to 3.
// - The channel register holds a 7-bit channel in bits 6:0, reset 2, with bit 7 reserved.
// - Setup bit 4 forces the pll lock indication for test, resetting to 0.
// - Setup bit 3 picks the air rate, 0 for 1 Mbps and 1 for 2 Mbps, resetting to 1.
// - Setup bits 2:1 pick transmit power from -18 dBm up to 0 dBm, resetting to 11.
// - The status byte is shifted out on the serial output while each command byte comes in.
// - Status bit 6 is set on each packet arrival and cleared by writing 1.
// - Status bit 5 is set when a packet is sent, after the acknowledge if that is on, cleared by 1.
// - Status bit 4 is set when retries run out, blocks new sends, and is cleared by writing 1.
// - Status bits 3:1 show the pipe at the receive head, 111 meaning empty, reset 111.
// - Each unmasked event flag pulls the interrupt pin low; masked flags leave it alone.
`timescale 1ns/1ps
module radio_retry_rf_status_regs #(
    parameter int unsigned RETRY_STEP_CYCLES = radio_regs_pkg::RETRY_STEP_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic spi_csn_n,
    input wire logic spi_sck,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    output logic irq_n,
    input wire logic mask_rx_ready,
    input wire logic mask_tx_sent,
    input wire logic mask_retry_exhausted,
    input wire logic rx_packet_arrived,
    input wire logic [2:0] rx_head_pipe,
    input wire logic tx_fifo_full,
    input wire logic tx_begin,
    input wire logic tx_end,
    input wire logic ack_received,
    input wire logic auto_acknowledge_short,
    output logic retransmit_req,
    output logic rx_listen,
    output logic [6:0] rf_channel_select,
    output logic air_rate_select,
    output logic [1:0] tx_power_level,
    output logic rx_amp_gain,
    output logic pll_lock_force
);
    radio_regs_pkg::bank_state_t st_reg;
    radio_regs_pkg::bank_state_t st_next;
    retry_if link ();

    function automatic logic [7:0] status_value(input radio_regs_pkg::bank_state_t s);
        logic [7:0] v;
        v = 8'h00;
        v[radio_regs_pkg::RX_READY_FLAG_BIT:radio_regs_pkg::EVENT_FLAGS_LSB] = s.flags;
        v[radio_regs_pkg::RX_PIPE_MSB:radio_regs_pkg::RX_PIPE_LSB] = s.pipe;
        v[radio_regs_pkg::TX_FULL_BIT] = s.tx_full;
        return v;
    endfunction

    function automatic logic [7:0] reg_read(input logic [4:0] addr,
                                            input radio_regs_pkg::bank_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            radio_regs_pkg::ADDR_RETRANSMIT_DELAY_COUNT: v = s.retr;
            radio_regs_pkg::ADDR_RF_CHANNEL_SELECT: v = {1'b0, s.chan};
            radio_regs_pkg::ADDR_RF_RATE_POWER_SETUP: v = {3'h0, s.setup};
            radio_regs_pkg::ADDR_EVENT_AND_PIPE_FLAGS: v = status_value(s);
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    logic sck_rise;
    logic sck_fall;
    logic byte_done;
    logic [7:0] rx_byte;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [2:0] flag_mask;
    logic [2:0] cmd_op;
    logic [4:0] cmd_addr;

    always_comb begin
        st_next = st_reg;
        flag_clr = 3'h0;
        sck_rise = !st_reg.sck_prev && spi_sck;
        sck_fall = st_reg.sck_prev && !spi_sck;
        rx_byte = {st_reg.shift_in[6:0], spi_mosi};
        byte_done = sck_rise && (st_reg.bit_cnt == 3'h7);
        cmd_op = st_reg.cmd[radio_regs_pkg::CMD_OP_MSB:radio_regs_pkg::CMD_OP_LSB];
        cmd_addr = st_reg.cmd[radio_regs_pkg::CMD_ADDR_MSB:0];
        st_next.sck_prev = spi_sck;
        st_next.pipe = rx_head_pipe;
        st_next.tx_full = tx_fifo_full;

        if (spi_csn_n) begin
            st_next.phase = radio_regs_pkg::SPI_IDLE;
            st_next.miso_oe_n = 1'b1;
            st_next.load_pending = 1'b0;
        end else if (st_reg.phase == radio_regs_pkg::SPI_IDLE) begin
            // status is loaded at select so its msb is ready before the first edge
            st_next.phase = radio_regs_pkg::SPI_CMD;
            st_next.bit_cnt = 3'h0;
            st_next.shift_out = status_value(st_reg);
            st_next.miso_oe_n = 1'b0;
            st_next.wrote = 1'b0;
            st_next.load_pending = 1'b0;
        end else begin
            if (sck_rise) begin
                st_next.shift_in = rx_byte;
                st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
            end
            if (byte_done) begin
                case (st_reg.phase)
                    radio_regs_pkg::SPI_CMD: begin
                        st_next.cmd = rx_byte;
                        st_next.phase = radio_regs_pkg::SPI_DATA;
                        st_next.load_pending = 1'b1;
                    end
                    radio_regs_pkg::SPI_DATA: begin
                        st_next.load_pending = 1'b1;
                        // only the first data byte of a write frame lands
                        if (cmd_op == radio_regs_pkg::CMD_OP_WRITE && !st_reg.wrote) begin
                            st_next.wrote = 1'b1;
                            case (cmd_addr)
                                radio_regs_pkg::ADDR_RETRANSMIT_DELAY_COUNT: begin
                                    st_next.retr = rx_byte;
                                end
                                radio_regs_pkg::ADDR_RF_CHANNEL_SELECT: begin
                                    st_next.chan = rx_byte[radio_regs_pkg::RF_CHANNEL_MSB:0];
                                end
                                radio_regs_pkg::ADDR_RF_RATE_POWER_SETUP: begin
                                    st_next.setup = rx_byte[radio_regs_pkg::RF_RATE_POWER_SETUP_MSB:0];
                                end
                                radio_regs_pkg::ADDR_EVENT_AND_PIPE_FLAGS: begin
                                    flag_clr = rx_byte[radio_regs_pkg::RX_READY_FLAG_BIT:
                                                       radio_regs_pkg::EVENT_FLAGS_LSB];
                                end
                                default: begin
                                    st_next.wrote = 1'b1;
                                end
                            endcase
                        end
                    end
                    default: begin
                        st_next.phase = radio_regs_pkg::SPI_IDLE;
                    end
                endcase
            end
            if (sck_fall) begin
                if (st_reg.load_pending) begin
                    st_next.load_pending = 1'b0;
                    if (cmd_op == radio_regs_pkg::CMD_OP_READ) begin
                        st_next.shift_out = reg_read(cmd_addr, st_reg);
                    end else begin
                        st_next.shift_out = 8'h00;
                    end
                end else begin
                    st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
                end
            end
        end

        // an event in the same cycle as its clear survives the clear
        flag_set = {rx_packet_arrived, link.tx_sent_evt, link.exhausted_evt};
        st_next.flags = (st_reg.flags & ~flag_clr) | flag_set;
        flag_mask = {mask_rx_ready, mask_tx_sent, mask_retry_exhausted};
        st_next.irq_n = ~|(st_next.flags & ~flag_mask);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '{phase: radio_regs_pkg::SPI_IDLE, bit_cnt: 3'h0, shift_in: 8'h00,
                        shift_out: 8'h00, load_pending: 1'b0, cmd: 8'h00, wrote: 1'b0,
                        sck_prev: 1'b0,
                        retr: radio_regs_pkg::RETRANSMIT_DELAY_COUNT_RESET,
                        chan: radio_regs_pkg::RF_CHANNEL_RESET,
                        setup: radio_regs_pkg::RF_RATE_POWER_SETUP_RESET,
                        flags: radio_regs_pkg::EVENT_FLAGS_RESET,
                        pipe: radio_regs_pkg::RX_PIPE_EMPTY, tx_full: 1'b0,
                        irq_n: 1'b1, miso_oe_n: 1'b1};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign link.delay_code =
        st_reg.retr[radio_regs_pkg::RETRY_DELAY_CODE_MSB:radio_regs_pkg::RETRY_DELAY_CODE_LSB];
    assign link.retry_limit =
        st_reg.retr[radio_regs_pkg::RETRY_LIMIT_MSB:radio_regs_pkg::RETRY_LIMIT_LSB];
    assign link.auto_ack = auto_acknowledge_short;
    assign link.blocked = st_reg.flags[radio_regs_pkg::RETRY_EXHAUSTED_FLAG_BIT -
                                       radio_regs_pkg::EVENT_FLAGS_LSB];
    assign link.tx_begin = tx_begin;
    assign link.tx_end = tx_end;
    assign link.ack_seen = ack_received;

    retry_engine #(
        .STEP_CYCLES(RETRY_STEP_CYCLES)
    ) u_retry_engine (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .link(link)
    );

    assign spi_miso = st_reg.shift_out[7];
    assign spi_miso_oe_n = st_reg.miso_oe_n;
    assign irq_n = st_reg.irq_n;
    assign retransmit_req = link.retransmit;
    assign rx_listen = link.listening;
    assign rf_channel_select = st_reg.chan;
    assign pll_lock_force = st_reg.setup[radio_regs_pkg::PLL_LOCK_FORCE_BIT];
    assign air_rate_select = st_reg.setup[radio_regs_pkg::AIR_RATE_SELECT_BIT];
    assign tx_power_level =
        st_reg.setup[radio_regs_pkg::TX_POWER_LEVEL_MSB:radio_regs_pkg::TX_POWER_LEVEL_LSB];
    assign rx_amp_gain = st_reg.setup[radio_regs_pkg::RX_AMP_GAIN_BIT];
endmodule

// ---- verif/radio_regs_chk.sv ----
// pin-level assertions for the retry, rf and status register bank
`timescale 1ns/1ps
module radio_regs_chk #(
    parameter int unsigned RETRY_STEP_CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic spi_csn_n,
    input wire logic spi_miso_oe_n,
    input wire logic irq_n,
    input wire logic mask_rx_ready,
    input wire logic mask_tx_sent,
    input wire logic mask_retry_exhausted,
    input wire logic rx_packet_arrived,
    input wire logic tx_end,
    input wire logic ack_received,
    input wire logic retransmit_req,
    input wire logic rx_listen,
    input wire logic [6:0] rf_channel_select
);
    logic [15:0] listen_len;
    // length of the current listen window, held one cycle after it closes then cleared, frozen with the design when ce is low
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            listen_len <= 16'h0000;
        end else if (ce) begin
            listen_len <= rx_listen ? listen_len + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence frame_open;
        $fell(spi_csn_n) ##1 !spi_csn_n;
    endsequence
    sequence all_masked;
        mask_rx_ready && mask_tx_sent && mask_retry_exhausted;
    endsequence
    sequence rx_event;
        rx_packet_arrived && !mask_rx_ready ##1 !mask_rx_ready;
    endsequence
    miso_drive_a: assert property (frame_open |-> ##[0:2] !spi_miso_oe_n)
        else $error("serial output not driven after select");
    miso_release_a: assert property (spi_csn_n [*4] |-> spi_miso_oe_n)
        else $error("serial output driven while deselected");
    irq_masked_a: assert property (all_masked [*2] |-> irq_n)
        else $error("interrupt low with every flag masked");
    rx_irq_a: assert property (rx_event |=> !irq_n)
        else $error("arrival did not pull interrupt low");
    listen_start_a: assert property ($rose(rx_listen) |-> $past(tx_end))
        else $error("listen window opened without end of send");
    ack_stop_a: assert property (ce && rx_listen && ack_received |=> !rx_listen)
        else $error("listen window not closed by acknowledge");
    retry_gap_a: assert property (retransmit_req |-> !rx_listen &&
        listen_len >= RETRY_STEP_CYCLES && listen_len % RETRY_STEP_CYCLES == 0 &&
        listen_len <= 16 * RETRY_STEP_CYCLES)
        else $error("retransmission not after a whole delay window");
    retry_pulse_a: assert property (retransmit_req |=> !retransmit_req)
        else $error("retransmit request longer than one cycle");
    chan_frame_a: assert property ($changed(rf_channel_select) |-> !spi_csn_n)
        else $error("channel changed outside a serial frame");
endmodule
bind radio_retry_rf_status_regs radio_regs_chk #(.RETRY_STEP_CYCLES(RETRY_STEP_CYCLES)) chk (
    .core_clk, .rst, .ce, .spi_csn_n, .spi_miso_oe_n, .irq_n, .mask_rx_ready, .mask_tx_sent,
    .mask_retry_exhausted, .rx_packet_arrived, .tx_end, .ack_received, .retransmit_req,
    .rx_listen, .rf_channel_select
);

// ---- verif/spi_host_model.sv ----
// host-side serial master that frames one register access at a time
`timescale 1ns/1ps
module spi_host_model (
    input wire logic core_clk,
    output logic spi_csn_n,
    output logic spi_sck,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe_n
);
    logic last_bit = 1'b0;
    logic miso_w;
    // a released output shows the inverse of its last bit, so stale data never matches
    assign miso_w = spi_miso_oe_n ? ~last_bit : spi_miso;
    always @(posedge core_clk) begin
        if (!spi_miso_oe_n) last_bit <= spi_miso;
    end
    initial begin
        spi_csn_n = 1'b1;
        spi_sck = 1'b0;
        spi_mosi = 1'b0;
    end
    // each sck level is held two or more core clocks, as the slave samples the pins
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                        output logic [7:0] st, output logic [7:0] rd);
        logic [15:0] tx;
        logic [15:0] rx;
        tx = {cmd, wd};
        spi_csn_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        for (int i = 15; i >= 0; i--) begin
            spi_mosi <= tx[i];
            repeat (2) @(posedge core_clk);
            rx[i] = miso_w;
            spi_sck <= 1'b1;
            repeat (2) @(posedge core_clk);
            spi_sck <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
        spi_csn_n <= 1'b1;
        spi_mosi <= ~tx[0];
        repeat (3) @(posedge core_clk);
        st = rx[15:8];
        rd = rx[7:0];
    endtask
endmodule

// ---- verif/tb_radio_retry_rf_status_regs.sv ----
// self-checking bench for the retry, rf and status register bank
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR %0t got %h want %h", $time, (a), (e)); end end
module tb_radio_retry_rf_status_regs;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic spi_csn_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe_n, irq_n;
    logic mask_rx_ready = 1'b0, mask_tx_sent = 1'b0, mask_retry_exhausted = 1'b0;
    logic rx_packet_arrived = 1'b0, tx_fifo_full = 1'b0, tx_begin = 1'b0, tx_end = 1'b0;
    logic ack_received = 1'b0, auto_acknowledge_short = 1'b0;
    logic [2:0] rx_head_pipe = 3'h7;
    logic retransmit_req, rx_listen, air_rate_select, rx_amp_gain, pll_lock_force;
    logic [6:0] rf_channel_select;
    logic [1:0] tx_power_level;
    logic [7:0] st, rv;
    logic [4:0] a_rt = radio_regs_pkg::ADDR_RETRANSMIT_DELAY_COUNT;
    logic [4:0] a_ch = radio_regs_pkg::ADDR_RF_CHANNEL_SELECT;
    logic [4:0] a_su = radio_regs_pkg::ADDR_RF_RATE_POWER_SETUP;
    logic [4:0] a_st = radio_regs_pkg::ADDR_EVENT_AND_PIPE_FLAGS;
    int err_total = 0, samples_checked = 0, cycles = 0, n;
    logic seen;
    radio_retry_rf_status_regs #(.RETRY_STEP_CYCLES(4)) dut (.core_clk, .rst, .ce, .spi_csn_n,
        .spi_sck, .spi_mosi, .spi_miso, .spi_miso_oe_n, .irq_n, .mask_rx_ready, .mask_tx_sent,
        .mask_retry_exhausted, .rx_packet_arrived, .rx_head_pipe, .tx_fifo_full, .tx_begin,
        .tx_end, .ack_received, .auto_acknowledge_short, .retransmit_req, .rx_listen,
        .rf_channel_select, .air_rate_select, .tx_power_level, .rx_amp_gain, .pll_lock_force);
    spi_host_model host (.core_clk, .spi_csn_n, .spi_sck, .spi_mosi, .spi_miso, .spi_miso_oe_n);
    always #12.5 core_clk = ~core_clk;
    function automatic logic [7:0] rc(input logic [4:0] a);
        return {radio_regs_pkg::CMD_OP_READ, a};
    endfunction
    function automatic logic [7:0] wc(input logic [4:0] a);
        return {radio_regs_pkg::CMD_OP_WRITE, a};
    endfunction
    task automatic rw(input logic [7:0] c, input logic [7:0] d);
        host.xfer(c, d, st, rv);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic begin_tx();
        tx_begin <= 1'b1;
        idle(1);
        tx_begin <= 1'b0;
        idle(3);
    endtask
    // ends one send and counts listen cycles until a retransmit request or 40 cycles
    task automatic listen();
        tx_end <= 1'b1;
        n = 0;
        seen = 1'b0;
        for (int k = 0; k < 40 && !seen; k++) begin
            @(posedge core_clk);
            tx_end <= 1'b0;
            #1;
            if (rx_listen === 1'b1) n++;
            if (retransmit_req === 1'b1) seen = 1'b1;
        end
        idle(3);
    endtask
    task automatic t_reset();
        rw(rc(a_rt), 8'h00);
        `CHK(rv, 8'h03)
        `CHK(st, 8'h0E)
        rw(rc(a_ch), 8'h00);
        `CHK(rv, 8'h02)
        rw(rc(a_su), 8'h00);
        `CHK(rv, 8'h0F)
        rw(rc(5'h1F), 8'h00);
        `CHK(rv, 8'h00)
    endtask
    task automatic t_regs();
        for (int i = 0; i < 32; i++) begin
            rw(wc(a_su), {3'h0, i[4:0]});
            rw(rc(a_su), 8'h00);
            `CHK(rv, {3'h0, i[4:0]})
            `CHK({pll_lock_force, air_rate_select, tx_power_level, rx_amp_gain}, i[4:0])
        end
        rw(wc(a_ch), 8'h7F);
        // unknown operation must leave the channel alone
        rw({3'h2, a_ch}, 8'h00);
        rw(rc(a_ch), 8'h00);
        `CHK(rv, 8'h7F)
        `CHK(rf_channel_select, 7'h7F)
        rw(wc(a_rt), 8'h33);
        rw(rc(a_rt), 8'h00);
        `CHK(rv, 8'h33)
    endtask
    task automatic t_flags();
        rx_head_pipe <= 3'h2;
        tx_fifo_full <= 1'b1;
        rx_packet_arrived <= 1'b1;
        idle(1);
        rx_packet_arrived <= 1'b0;
        idle(3);
        `CHK(irq_n, 1'b0)
        {mask_rx_ready, mask_tx_sent, mask_retry_exhausted} <= 3'h7;
        idle(3);
        `CHK(irq_n, 1'b1)
        rw(rc(a_st), 8'h00);
        `CHK(st, 8'h45)
        // clear the ready flag, then look again for more payloads
        rw(wc(a_st), 8'h40);
        rw(rc(a_st), 8'h00);
        `CHK(rv, 8'h05)
        {mask_rx_ready, mask_tx_sent, mask_retry_exhausted} <= 3'h0;
        rx_head_pipe <= 3'h7;
        tx_fifo_full <= 1'b0;
        idle(3);
        `CHK(irq_n, 1'b1)
    endtask
    task automatic t_sent();
        begin_tx();
        listen();
        `CHK(n, 0)
        rw(rc(a_st), 8'h00);
        `CHK(rv, 8'h2E)
        rw(wc(a_st), 8'h20);
        auto_acknowledge_short <= 1'b1;
        begin_tx();
        tx_end <= 1'b1;
        idle(1);
        tx_end <= 1'b0;
        // outputs read at an edge still show what the previous edge launched
        idle(2);
        `CHK(rx_listen, 1'b1)
        ack_received <= 1'b1;
        idle(1);
        ack_received <= 1'b0;
        idle(2);
        `CHK(rx_listen, 1'b0)
        rw(rc(a_st), 8'h00);
        `CHK(rv, 8'h2E)
        rw(wc(a_st), 8'h20);
    endtask
    task automatic t_retry();
        rw(wc(a_rt), 8'h11);
        begin_tx();
        listen();
        `CHK(n, 8)
        `CHK(seen, 1'b1)
        listen();
        `CHK(seen, 1'b0)
        `CHK(irq_n, 1'b0)
        rw(rc(a_st), 8'h00);
        `CHK(rv, 8'h1E)
        begin_tx();
        listen();
        `CHK(n, 0)
        rw(wc(a_st), 8'h10);
        begin_tx();
        listen();
        `CHK(n, 8)
    endtask
    task automatic end_sim();
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        idle(2);
        rst <= 1'b0;
        idle(1);
        t_reset();
        t_regs();
        t_flags();
        t_sent();
        t_retry();
        end_sim();
    end
endmodule
